// ---- include/hav_pkg.sv ----
// =====================================================
// Headphone amplifier control constants
package hav_pkg;
  // =====================================================
  // Serial bus device address bytes
  localparam logic [7:0] DEV_WR_ADDR = 8'hC0;
  localparam logic [7:0] DEV_RD_ADDR = 8'hC1;

  // =====================================================
  // Device register offsets
  localparam logic [7:0] REG_CTRL = 8'h01;
  localparam logic [7:0] REG_VOL = 8'h02;
  localparam logic [7:0] REG_FLOAT = 8'h03;

  // =====================================================
  // Field positions
  localparam int CTRL_SHUTDOWN_BIT = 0;
  localparam int CTRL_RIGHT_ON_BIT = 6;
  localparam int CTRL_LEFT_ON_BIT = 7;
  localparam int VOL_CODE_LSB = 1;
  localparam int VOL_RIGHT_MUTE_BIT = 6;
  localparam int VOL_LEFT_MUTE_BIT = 7;
  localparam int FLOAT_RIGHT_BIT = 0;
  localparam int FLOAT_LEFT_BIT = 1;

  // =====================================================
  // Power-up values
  localparam logic [7:0] CTRL_RST = 8'h01;
  localparam logic [7:0] VOL_RST = 8'hC0;
  localparam logic [7:0] FLOAT_RST = 8'h00;

  // =====================================================
  // Gain table, in dB
  localparam int GAIN_MUTE_DB = -80;
  localparam int GAIN_MIN_DB = -59;
  localparam int BAND1_LAST = 8;
  localparam int BAND1_STEP_DB = 4;
  localparam int BAND2_BASE_DB = -27;
  localparam int BAND2_LAST = 16;
  localparam int BAND2_STEP_DB = 2;
  localparam int BAND3_BASE_DB = -11;
  localparam int BAND3_STEP_DB = 1;

  // =====================================================
  // Controller register offsets
  localparam logic [2:0] HC_TARGET = 3'h0;
  localparam logic [2:0] HC_WDATA = 3'h1;
  localparam logic [2:0] HC_CMD = 3'h2;
  localparam logic [2:0] HC_STATUS = 3'h3;
  localparam logic [2:0] HC_RDATA = 3'h4;
  localparam logic [2:0] HC_SHADOW = 3'h5;
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_READ_BIT = 1;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_NACK_BIT = 2;
  localparam int ST_REFUSED_BIT = 3;
endpackage

// ---- include/hav_if.sv ----
`timescale 1ns/1ps
// =====================================================
// Register link between controller and amplifier
interface hav_if;
  logic req;
  logic [7:0] dev_addr;
  logic [7:0] reg_addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;

  modport dev (
    input req,
    input dev_addr,
    input reg_addr,
    input wdata,
    output ack,
    output rdata
  );

  modport host (
    output req,
    output dev_addr,
    output reg_addr,
    output wdata,
    input ack,
    input rdata
  );
endinterface

// ---- hw/hav_dev.sv ----
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module hav_dev
  import hav_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register link
  hav_if.dev link,
  // Power stage
  output logic regulator_on,
  output logic charge_pump_on,
  // Per channel, index 1 left, 0 right
  output logic [1:0] amp_on,
  output logic [1:0] amp_float,
  output logic [1:0] amp_mute,
  output logic [1:0] mute_assured,
  output logic [1:0][7:0] gain_db
);

  // =====================================================
  // Gain decode
  function automatic logic [7:0] code_gain(input logic [4:0] code);
    int c;
    c = int'(code);
    if (c <= BAND1_LAST) begin
      return 8'(GAIN_MIN_DB + BAND1_STEP_DB * c);
    end else if (c <= BAND2_LAST) begin
      return 8'(BAND2_BASE_DB + BAND2_STEP_DB * (c - BAND1_LAST));
    end else begin
      return 8'(BAND3_BASE_DB + BAND3_STEP_DB * (c - BAND2_LAST));
    end
  endfunction

  typedef enum logic {
    PWR_SHUTDOWN,
    PWR_ACTIVE
  } hav_pwr_e;

  // =====================================================
  // Control state
  logic shutdown_request;
  logic [1:0] chan_on;
  logic [1:0] mute;
  logic [4:0] vol_code;
  logic [1:0] out_float;
  hav_pwr_e pwr;
  hav_pwr_e next_pwr;

  logic sel_wr;
  logic sel_rd;
  logic [7:0] rd_byte;

  // =====================================================
  // Link decode
  assign sel_wr = link.req && (link.dev_addr == DEV_WR_ADDR);
  assign sel_rd = link.req && (link.dev_addr == DEV_RD_ADDR);

  // =====================================================
  // Register writes
  // Writes stay open in shutdown, otherwise the part could never wake.
  // Only reset and a write touch these bits, so shutdown keeps them.
  always_ff @(posedge clk) begin
    if (reset) begin
      shutdown_request <= CTRL_RST[CTRL_SHUTDOWN_BIT];
      chan_on[1] <= CTRL_RST[CTRL_LEFT_ON_BIT];
      chan_on[0] <= CTRL_RST[CTRL_RIGHT_ON_BIT];
    end else if (sel_wr && link.reg_addr == REG_CTRL) begin
      // Whole byte replaces the enables too
      shutdown_request <= link.wdata[CTRL_SHUTDOWN_BIT];
      chan_on[1] <= link.wdata[CTRL_LEFT_ON_BIT];
      chan_on[0] <= link.wdata[CTRL_RIGHT_ON_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mute[1] <= VOL_RST[VOL_LEFT_MUTE_BIT];
      mute[0] <= VOL_RST[VOL_RIGHT_MUTE_BIT];
      vol_code <= VOL_RST[VOL_CODE_LSB +: 5];
    end else if (sel_wr && link.reg_addr == REG_VOL) begin
      mute[1] <= link.wdata[VOL_LEFT_MUTE_BIT];
      mute[0] <= link.wdata[VOL_RIGHT_MUTE_BIT];
      // Bit 0 of the byte is dropped here
      vol_code <= link.wdata[VOL_CODE_LSB +: 5];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      out_float[1] <= FLOAT_RST[FLOAT_LEFT_BIT];
      out_float[0] <= FLOAT_RST[FLOAT_RIGHT_BIT];
    end else if (sel_wr && link.reg_addr == REG_FLOAT) begin
      out_float[1] <= link.wdata[FLOAT_LEFT_BIT];
      out_float[0] <= link.wdata[FLOAT_RIGHT_BIT];
    end
  end

  // =====================================================
  // Readback
  always_comb begin
    rd_byte = 8'h00;
    case (link.reg_addr)
      REG_CTRL: begin
        rd_byte[CTRL_SHUTDOWN_BIT] = shutdown_request;
        rd_byte[CTRL_LEFT_ON_BIT] = chan_on[1];
        rd_byte[CTRL_RIGHT_ON_BIT] = chan_on[0];
      end
      REG_VOL: begin
        rd_byte[VOL_LEFT_MUTE_BIT] = mute[1];
        rd_byte[VOL_RIGHT_MUTE_BIT] = mute[0];
        rd_byte[VOL_CODE_LSB +: 5] = vol_code;
      end
      REG_FLOAT: begin
        rd_byte[FLOAT_LEFT_BIT] = out_float[1];
        rd_byte[FLOAT_RIGHT_BIT] = out_float[0];
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // Unmapped offsets are still acknowledged; writes to them are dropped
  always_ff @(posedge clk) begin
    if (reset) begin
      link.ack <= 1'b0;
    end else begin
      link.ack <= sel_wr || sel_rd;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      link.rdata <= 8'h00;
    end else if (sel_rd) begin
      link.rdata <= rd_byte;
    end else begin
      link.rdata <= 8'h00;
    end
  end

  // =====================================================
  // Power state
  always_comb begin
    next_pwr = pwr;
    case (pwr)
      PWR_SHUTDOWN: begin
        if (!shutdown_request) begin
          next_pwr = PWR_ACTIVE;
        end
      end
      PWR_ACTIVE: begin
        if (shutdown_request) begin
          next_pwr = PWR_SHUTDOWN;
        end
      end
      default: begin
        next_pwr = PWR_SHUTDOWN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pwr <= PWR_SHUTDOWN;
    end else begin
      pwr <= next_pwr;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      regulator_on <= 1'b0;
      charge_pump_on <= 1'b0;
    end else begin
      regulator_on <= (next_pwr == PWR_ACTIVE);
      charge_pump_on <= (next_pwr == PWR_ACTIVE);
    end
  end

  // =====================================================
  // Channel outputs
  // Outputs follow the register state one edge later, same as the pump.
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      logic silenced;
      logic active;
      assign active = (next_pwr == PWR_ACTIVE);
      assign silenced = mute[ch] || out_float[ch] || (&mute);

      always_ff @(posedge clk) begin
        if (reset) begin
          amp_on[ch] <= 1'b0;
          amp_float[ch] <= 1'b0;
          amp_mute[ch] <= 1'b1;
          mute_assured[ch] <= 1'b0;
        end else begin
          // Floating driver must never also drive
          amp_on[ch] <= active && chan_on[ch] && !out_float[ch];
          amp_float[ch] <= out_float[ch];
          amp_mute[ch] <= silenced;
          mute_assured[ch] <= mute[ch] && active && chan_on[ch];
        end
      end

      always_ff @(posedge clk) begin
        if (reset) begin
          gain_db[ch] <= 8'(GAIN_MUTE_DB);
        end else if (silenced) begin
          gain_db[ch] <= 8'(GAIN_MUTE_DB);
        end else begin
          gain_db[ch] <= code_gain(vol_code);
        end
      end
    end
  endgenerate

endmodule // hav_dev

// ---- hw/hav_host.sv ----
`timescale 1ns/1ps
module hav_host
  import hav_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register link
  hav_if.host link,
  // Software port
  input wire logic [2:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata
);

  typedef enum logic [2:0] {
    HS_IDLE,
    HS_PRE,
    HS_PRE_WAIT,
    HS_MAIN,
    HS_MAIN_WAIT
  } hav_hst_e;

  hav_hst_e st;
  logic [7:0] target;
  logic [7:0] wbyte;
  logic [7:0] main_byte;
  logic [7:0] main_next;
  logic [7:0] rd_val;
  logic [7:0] shadow;
  logic done;
  logic nack;
  logic refused;
  logic go_wr;
  logic go_rd;
  logic bad_float;
  logic need_pre;
  logic set_done;
  logic set_nack;
  logic clr;

  // =====================================================
  // Software decode
  assign go_wr = sw_wr && sw_addr == HC_CMD && sw_wdata[CMD_WRITE_BIT] && st == HS_IDLE;
  assign go_rd = sw_wr && sw_addr == HC_CMD && sw_wdata[CMD_READ_BIT] && !go_wr
    && st == HS_IDLE;
  assign clr = sw_wr && sw_addr == HC_STATUS;
  // Float only from active with both channels off
  assign bad_float = target == REG_FLOAT && wbyte[1:0] != 2'h0
    && (shadow[CTRL_SHUTDOWN_BIT] || shadow[CTRL_LEFT_ON_BIT]
    || shadow[CTRL_RIGHT_ON_BIT]);
  assign need_pre = target == REG_CTRL && wbyte[CTRL_SHUTDOWN_BIT]
    && !shadow[CTRL_SHUTDOWN_BIT];
  assign set_done = st == HS_MAIN_WAIT && link.ack;

  // Shutdown keeps enables high for lowest current, on the first byte sent too
  always_comb begin
    main_next = wbyte;
    if (target == REG_CTRL && wbyte[CTRL_SHUTDOWN_BIT]) begin
      main_next[CTRL_LEFT_ON_BIT] = 1'b1;
      main_next[CTRL_RIGHT_ON_BIT] = 1'b1;
    end
  end
  assign set_nack = (st == HS_MAIN_WAIT || st == HS_PRE_WAIT) && !link.ack;

  always_ff @(posedge clk) begin
    if (reset) begin
      target <= 8'h00;
      wbyte <= 8'h00;
    end else if (st == HS_IDLE && sw_wr && sw_addr == HC_TARGET) begin
      target <= sw_wdata;
    end else if (st == HS_IDLE && sw_wr && sw_addr == HC_WDATA) begin
      wbyte <= sw_wdata;
    end
  end

  // =====================================================
  // Transfer sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      st <= HS_IDLE;
      main_byte <= 8'h00;
      link.wdata <= 8'h00;
      link.dev_addr <= 8'h00;
      link.reg_addr <= 8'h00;
    end else begin
      case (st)
        HS_IDLE: begin
          main_byte <= main_next;
          link.reg_addr <= target;
          if (go_wr && !bad_float) begin
            link.dev_addr <= DEV_WR_ADDR;
            // Full byte always sent, never a bit merge
            link.wdata <= need_pre ? 8'hC0 : main_next;
            st <= need_pre ? HS_PRE : HS_MAIN;
          end else if (go_rd) begin
            link.dev_addr <= DEV_RD_ADDR;
            link.wdata <= 8'h00;
            st <= HS_MAIN;
          end
        end
        HS_PRE: st <= HS_PRE_WAIT;
        HS_PRE_WAIT: begin
          link.wdata <= main_byte;
          st <= link.ack ? HS_MAIN : HS_IDLE;
        end
        HS_MAIN: begin
          if (link.dev_addr == DEV_WR_ADDR) begin
            link.wdata <= main_byte;
          end
          st <= HS_MAIN_WAIT;
        end
        HS_MAIN_WAIT: st <= HS_IDLE;
        default: st <= HS_IDLE;
      endcase
    end
  end

  // Request held one cycle in each send state
  assign link.req = (st == HS_PRE) || (st == HS_MAIN);

  // =====================================================
  // Shadow of the device control byte
  always_ff @(posedge clk) begin
    if (reset) begin
      shadow <= CTRL_RST;
    end else if (link.ack && link.dev_addr == DEV_WR_ADDR && link.reg_addr == REG_CTRL
      && (st == HS_PRE_WAIT || st == HS_MAIN_WAIT)) begin
      shadow <= link.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rd_val <= 8'h00;
    end else if (set_done && link.dev_addr == DEV_RD_ADDR) begin
      rd_val <= link.rdata;
    end
  end

  // Set beats a same-cycle clear
  always_ff @(posedge clk) begin
    if (reset) begin
      done <= 1'b0;
      nack <= 1'b0;
      refused <= 1'b0;
    end else begin
      done <= set_done || (done && !(clr && sw_wdata[ST_DONE_BIT]));
      nack <= set_nack || (nack && !(clr && sw_wdata[ST_NACK_BIT]));
      refused <= (go_wr && bad_float)
        || (refused && !(clr && sw_wdata[ST_REFUSED_BIT]));
    end
  end

  // =====================================================
  // Software readback, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      sw_rdata <= 8'h00;
    end else if (sw_rd) begin
      case (sw_addr)
        HC_TARGET: sw_rdata <= target;
        HC_WDATA: sw_rdata <= wbyte;
        HC_STATUS: sw_rdata <= {4'h0, refused, nack, done, st != HS_IDLE};
        HC_RDATA: sw_rdata <= rd_val;
        HC_SHADOW: sw_rdata <= shadow;
        default: sw_rdata <= 8'h00;
      endcase
    end else begin
      sw_rdata <= 8'h00;
    end
  end

endmodule // hav_host

// ---- sim/hav_checker.sv ----
`timescale 1ns/1ps
// ==========================================
// Link checks between controller and amplifier
module hav_checker
  import hav_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register link
  input wire logic req,
  input wire logic [7:0] dev_addr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata
);
  logic [7:0] last_ctrl;
  logic wr_go;
  assign wr_go = req && dev_addr == DEV_WR_ADDR;

  // Last control byte sent; lets the order of host writes be judged
  always_ff @(posedge clk) begin
    if (reset) begin
      last_ctrl <= CTRL_RST;
    end else if (wr_go && reg_addr == REG_CTRL) begin
      last_ctrl <= wdata;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // ==========================================
  // Answers and host write order
  ack_answer_a: assert property (
    req && (dev_addr == DEV_WR_ADDR || dev_addr == DEV_RD_ADDR) |=> ack)
    else $error("request not acknowledged");
  ack_cause_a: assert property (
    ack |-> $past(req) && ($past(dev_addr) == DEV_WR_ADDR || $past(dev_addr) == DEV_RD_ADDR))
    else $error("acknowledge without a valid request");
  rdata_idle_a: assert property (
    rdata != 8'h00 |-> ack && $past(dev_addr) == DEV_RD_ADDR)
    else $error("read data outside a read answer");
  vol_lsb_a: assert property (
    ack && $past(dev_addr) == DEV_RD_ADDR && $past(reg_addr) == REG_VOL |-> !rdata[0])
    else $error("volume low bit read back set");
  ctrl_reserved_a: assert property (
    ack && $past(dev_addr) == DEV_RD_ADDR && $past(reg_addr) == REG_CTRL |-> rdata[5:1] == 5'h00)
    else $error("control reserved bits nonzero");
  float_reserved_a: assert property (
    ack && $past(dev_addr) == DEV_RD_ADDR && $past(reg_addr) == REG_FLOAT |-> rdata[7:2] == 6'h00)
    else $error("float reserved bits nonzero");
  unmapped_zero_a: assert property (
    ack && $past(dev_addr) == DEV_RD_ADDR && ($past(reg_addr) > REG_FLOAT ||
    $past(reg_addr) == 8'h00) |-> rdata == 8'h00)
    else $error("unmapped register read nonzero");
  shut_enables_a: assert property (
    wr_go && reg_addr == REG_CTRL && wdata[0] |-> wdata[7:6] == 2'b11)
    else $error("shutdown written without both enables");
  shut_order_a: assert property (
    wr_go && reg_addr == REG_CTRL && wdata[0] && !last_ctrl[0] |-> last_ctrl[7:6] == 2'b11)
    else $error("shutdown entered before enables were set");
  float_guard_a: assert property (
    wr_go && reg_addr == REG_FLOAT && wdata[1:0] != 2'b00 |->
    {last_ctrl[7:6], last_ctrl[0]} == 3'b000)
    else $error("float set while active state not met");
endmodule // hav_checker

// ---- sim/test_headphone_amp_mode_volume_ctrl.sv ----
`timescale 1ns/1ps
// ==========================================
// Bench: controller and amplifier joined by the link
module test_headphone_amp_mode_volume_ctrl
  import hav_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] sw_addr = 3'h0;
  logic [7:0] sw_wdata = 8'h00;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [7:0] sw_rdata;
  logic regulator_on, charge_pump_on;
  logic [1:0] amp_on, amp_float, amp_mute, mute_assured;
  logic [1:0][7:0] gain_db;
  logic [7:0] st;
  logic [7:0] rd;
  int error_cnt = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  hav_if link();
  hav_dev u_hav_dev (.clk(clk), .reset(reset), .link(link.dev), .regulator_on(regulator_on),
    .charge_pump_on(charge_pump_on), .amp_on(amp_on), .amp_float(amp_float),
    .amp_mute(amp_mute), .mute_assured(mute_assured), .gain_db(gain_db));
  hav_host u_hav_host (.clk(clk), .reset(reset), .link(link.host), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
  hav_checker u_hav_checker (.clk(clk), .reset(reset), .req(link.req),
    .dev_addr(link.dev_addr), .reg_addr(link.reg_addr), .wdata(link.wdata),
    .ack(link.ack), .rdata(link.rdata));

  // ==========================================
  // Helpers
  task automatic complete_run();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic sw_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic sw_read(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1;
    d = sw_rdata;
  endtask

  task automatic xfer(input logic [7:0] ra, input logic [7:0] wd, input logic is_rd);
    int n;
    n = 0;
    sw_write(HC_TARGET, ra);
    sw_write(HC_WDATA, wd);
    sw_write(HC_CMD, is_rd ? 8'h02 : 8'h01);
    do begin
      sw_read(HC_STATUS, st);
      n++;
    end while (st[ST_BUSY_BIT] !== 1'b0 && n < 20);
    sw_write(HC_STATUS, 8'h0E);
  endtask

  task automatic dev_wr(input logic [7:0] ra, input logic [7:0] wd);
    xfer(ra, wd, 1'b0);
    check8("write_status", 8'h02, st);
  endtask

  task automatic dev_rd(input logic [7:0] ra, input logic [7:0] exp);
    xfer(ra, 8'h00, 1'b1);
    sw_read(HC_RDATA, rd);
    check8("readback", exp, rd);
  endtask

  // Gain bands: 4 dB up to code 8, 2 dB up to 16, then 1 dB
  function automatic logic [7:0] gain_of(input int c);
    int g;
    if (c <= 8) g = -59 + 4 * c;
    else if (c <= 16) g = -27 + 2 * (c - 8);
    else g = -11 + (c - 16);
    return 8'(g);
  endfunction

  // ==========================================
  // Scenarios
  task automatic t_power_up();
    dev_rd(REG_CTRL, 8'h01);
    dev_rd(REG_VOL, 8'hC0);
    dev_rd(REG_FLOAT, 8'h00);
    check8("power", 8'h00, {6'h00, regulator_on, charge_pump_on});
    check8("amp_on", 8'h00, {6'h00, amp_on});
    check8("amp_mute", 8'h03, {6'h00, amp_mute});
    check8("gain_left", 8'hB0, gain_db[1]);
    dev_wr(REG_CTRL, 8'h01);
    dev_rd(REG_CTRL, 8'hC1);
  endtask

  task automatic t_float_refused();
    xfer(REG_FLOAT, 8'h03, 1'b0);
    check8("refuse_status", 8'h08, st);
    dev_rd(REG_FLOAT, 8'h00);
  endtask

  task automatic t_float();
    dev_wr(REG_CTRL, 8'h00);
    check8("power", 8'h03, {6'h00, regulator_on, charge_pump_on});
    dev_wr(REG_FLOAT, 8'h02);
    check8("amp_float", 8'h02, {6'h00, amp_float});
    dev_wr(REG_FLOAT, 8'h01);
    check8("amp_float", 8'h01, {6'h00, amp_float});
    dev_wr(REG_FLOAT, 8'hFF);
    dev_rd(REG_FLOAT, 8'h03);
    dev_wr(REG_FLOAT, 8'h00);
    check8("amp_float", 8'h00, {6'h00, amp_float});
  endtask

  task automatic t_gain();
    dev_wr(REG_CTRL, 8'hC0);
    check8("amp_on", 8'h03, {6'h00, amp_on});
    for (int c = 0; c < 32; c++) begin
      dev_wr(REG_VOL, {2'b00, 5'(c), 1'b1});
      check8("gain_left", gain_of(c), gain_db[1]);
      check8("gain_right", gain_of(c), gain_db[0]);
    end
    dev_rd(REG_VOL, 8'h3E);
  endtask

  task automatic t_mute();
    dev_wr(REG_VOL, 8'h9E);
    check8("gain_left", 8'hB0, gain_db[1]);
    check8("gain_right", gain_of(15), gain_db[0]);
    check8("assured", 8'h02, {6'h00, mute_assured});
    dev_wr(REG_VOL, 8'h5E);
    check8("amp_mute", 8'h01, {6'h00, amp_mute});
    dev_wr(REG_VOL, 8'hFE);
    check8("gain_left", 8'hB0, gain_db[1]);
    check8("gain_right", 8'hB0, gain_db[0]);
  endtask

  task automatic t_shutdown();
    dev_wr(REG_CTRL, 8'h01);
    check8("power", 8'h00, {6'h00, regulator_on, charge_pump_on});
    check8("amp_on", 8'h00, {6'h00, amp_on});
    check8("assured", 8'h00, {6'h00, mute_assured});
    dev_rd(REG_CTRL, 8'hC1);
    sw_read(HC_SHADOW, rd);
    check8("shadow", 8'hC1, rd);
    dev_rd(REG_VOL, 8'hFE);
    dev_wr(REG_CTRL, 8'h40);
    dev_rd(REG_CTRL, 8'h40);
    check8("amp_on", 8'h01, {6'h00, amp_on});
  endtask

  task automatic t_unmapped();
    dev_wr(8'h05, 8'hA5);
    dev_rd(8'h05, 8'h00);
    dev_rd(8'h04, 8'h00);
  endtask

  // ==========================================
  // Sequence and hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_power_up();
    t_float_refused();
    t_float();
    t_gain();
    t_mute();
    t_shutdown();
    t_unmapped();
    complete_run();
  end
endmodule // test_headphone_amp_mode_volume_ctrl
